//--- rtl/ext_tick_divider.sv
// Purpose: Six-stage divider clocked by the external tick pin
// Assumes: Tick clock may stop between bursts; halt arrives as a level
// Notes:   Each seconds increment leaves as a toggle for the system clock
`timescale 1ns/1ns
`default_nettype none
module ext_tick_divider (
	input  wire logic ext_tick_clk,
	input  wire logic rst_lvl,
	input  wire logic halt_lvl,
	output logic      sec_toggle_q
);
	import rtc_timebase_pkg::*;

	logic [1:0] rst_s_q;
	logic [1:0] halt_s_q;
	logic [5:0] div_q;
	logic [5:0] div_d;
	logic       carry;

	// ************************************************************
	// Level crossings into the tick domain
	// ************************************************************
	always_ff @(posedge ext_tick_clk) begin
		rst_s_q  <= {rst_s_q[0], rst_lvl};
		halt_s_q <= {halt_s_q[0], halt_lvl};
	end

	// ************************************************************
	// Divider; increment at count 0x1D, period 64
	// ************************************************************
	// Halt sync eats two edges after release, so carry sits two early
	assign div_d = halt_s_q[1] ? 6'h00 : div_q + 6'h01;
	assign carry = !halt_s_q[1] && div_q == 6'h1D;

	always_ff @(posedge ext_tick_clk) begin
		if (rst_s_q[1]) begin
			div_q        <= 6'h00;
			sec_toggle_q <= 1'b0;
		end else begin
			div_q <= div_d;
			if (carry) begin
				sec_toggle_q <= !sec_toggle_q;
			end
		end
	end

	property p_ext_halt;
		@(posedge ext_tick_clk) disable iff (rst_s_q[1])
		halt_s_q[1] |=> div_q == 6'h00;
	endproperty
	a_ext_halt: assert property (p_ext_halt) else $error("divider not held");

	property p_ext_first;
		@(posedge ext_tick_clk) disable iff (rst_s_q[1])
		(div_q == 6'h1D && !halt_s_q[1]) |=> $changed(sec_toggle_q);
	endproperty
	a_ext_first: assert property (p_ext_first) else $error("no tick at edge 32");
endmodule : ext_tick_divider
`default_nettype wire

//--- rtl/rtc_timebase.sv
// Purpose: Countdown timer, prescaler, halt, test tick and reset logic
// Assumes: Serial engine presents byte accesses on the register port
// Notes:   Oscillator and bus pins are synchronised before use
// Behaviour
// - Eight-bit countdown at offset 0x0F, control register at 0x0E.
// - Source select picks 4.096 kHz, 64 Hz, 1 Hz, 1/60 Hz; resets to 11.
// - Control bit 7 enables the countdown; resets to 0.
// - Enabled counter counts down and sets the flag at each end.
// - Flag stays set until cleared over the register interface.
// - With irq enable the interrupt pin shows the flag, else undriven.
// - Pulse select picks a pulse per period or a level following flag.
// - Reading the count returns the live value; no freeze.
// - Period is loaded value over source frequency; values 1 to 0xFF, 0 never ends.
// - External test bit turns the square wave pin into the tick input.
// - In test mode every 64 rising edges give one seconds increment.
// - Halt bit holds the upper prescaler stages at zero until software clears it.
// - After halt release in test mode, first increment at edge 32.
// - While halted upper prescaler stages reset; no one-second ticks.
// - While halted 32.768 kHz output continues, slower selections stop.
// - Two low stages keep running; first increment near 0.5078 s.
// - Stopped oscillator resets the interface; bus access refused.
// - Reset loads control registers, sets alarm and square_wave_pin bit 7.
// - Override entry leaves reset at once and allows bus access.
// - Writing permit to 0 ends override; the internal reset then reloads permit to 1.
`timescale 1ns/1ns
`default_nettype none
module rtc_timebase
	import rtc_timebase_pkg::*;
#(
	parameter int OSC_STOP_CYCLES = OSC_STOP_CYC
) (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       osc_pin,
	input  wire logic       scl_pin,
	input  wire logic       sda_pin,
	input  wire logic       ext_tick_clk,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [3:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	output logic [7:0]      reg_rdata_q,
	output logic            reg_ack_q,
	output logic            iface_rst_q,
	output logic            sec_tick_q,
	output logic            irq_n_q,
	output logic            sq_out_q,
	output logic            sq_oe_n_q
);

	// ************************************************************
	// Pin synchronisers and oscillator watchdog
	// ************************************************************
	logic [2:0]  osc_s_q;
	logic [1:0]  scl_s_q;
	logic [1:0]  sda_s_q;
	logic        scl_old_q;
	logic [31:0] stop_cnt_q;
	logic        osc_tick;
	logic        osc_stopped;

	always_ff @(posedge clk) begin
		osc_s_q <= {osc_s_q[1:0], osc_pin};
		scl_s_q <= {scl_s_q[0], scl_pin};
		sda_s_q <= {sda_s_q[0], sda_pin};
		scl_old_q <= scl_s_q[1];
	end

	assign osc_tick    = osc_s_q[1] && !osc_s_q[2];
	assign osc_stopped = stop_cnt_q >= 32'(OSC_STOP_CYCLES);

	always_ff @(posedge clk) begin
		if (sys_rst || osc_tick) begin
			stop_cnt_q <= 32'h0;
		end else if (!osc_stopped) begin
			stop_cnt_q <= stop_cnt_q + 32'h1;
		end
	end

	// ************************************************************
	// Reset override entry
	// ************************************************************
	// Pattern: SCL falls with SDA low, after SCL stood high long enough
	logic [15:0] ovr_hi_q;
	logic [3:0]  ovr_cnt_q;
	logic        override_q;
	logic        rst_int_q;
	logic [7:0]  primary_q;
	logic        scl_fall;
	logic        ovr_step;
	logic        permit_clear;

	assign scl_fall = scl_old_q && !scl_s_q[1];
	assign ovr_step = scl_fall && !sda_s_q[1] &&
		ovr_hi_q >= 16'(OVR_MIN_CYC);
	assign permit_clear = reg_wr && !rst_int_q &&
		reg_addr == PRIMARY_CONTROL_OFS && !reg_wdata[PERMIT_BIT];

	always_ff @(posedge clk) begin
		if (sys_rst || !rst_int_q || !scl_s_q[1]) begin
			ovr_hi_q <= 16'h0;
		end else if (ovr_hi_q != 16'hFFFF) begin
			ovr_hi_q <= ovr_hi_q + 16'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ovr_cnt_q  <= 4'h0;
			override_q <= 1'b0;
		end else if (permit_clear) begin
			ovr_cnt_q  <= 4'h0;
			override_q <= 1'b0;
		end else if (rst_int_q && primary_q[PERMIT_BIT] && ovr_step) begin
			ovr_cnt_q <= ovr_cnt_q + 4'h1;
			if (ovr_cnt_q == 4'(OVR_TOGGLES - 1)) begin
				override_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rst_int_q <= 1'b1;
		end else begin
			rst_int_q <= osc_stopped && !override_q;
		end
	end

	// ************************************************************
	// Registers
	// ************************************************************
	logic [7:0] secondary_q;
	logic [7:0] square_wave_pin_ctl_q;
	logic [7:0] alarm_q [4];
	logic       cd_enable_q;
	logic [1:0] cd_src_q;
	logic [7:0] cd_count_q;
	logic [7:0] cd_load_q;
	logic       acc_ok;
	logic       wr_primary;
	logic       wr_secondary;
	logic       wr_cd_ctl;
	logic       wr_cd_val;
	logic       wr_square_wave_pin;
	logic       wr_alarm;
	logic [1:0] alarm_idx;
	logic       flag_set;
	logic       flag_clr;
	logic       flag_d;
	logic [7:0] rdata_d;

	assign acc_ok       = !rst_int_q;
	assign wr_primary   = reg_wr && acc_ok && reg_addr == PRIMARY_CONTROL_OFS;
	assign wr_secondary = reg_wr && acc_ok &&
		reg_addr == SECONDARY_CONTROL_OFS;
	assign wr_cd_ctl    = reg_wr && acc_ok &&
		reg_addr == COUNTDOWN_CONTROL_OFS;
	assign wr_cd_val    = reg_wr && acc_ok && reg_addr == COUNTDOWN_VALUE_OFS;
	assign wr_square_wave_pin    = reg_wr && acc_ok && reg_addr == SQUARE_WAVE_PIN_CONTROL_OFS;
	assign alarm_idx    = 2'(reg_addr - ALARM_FIRST_OFS);
	assign wr_alarm     = reg_wr && acc_ok && reg_addr >= ALARM_FIRST_OFS &&
		reg_addr < SQUARE_WAVE_PIN_CONTROL_OFS;
	assign flag_clr     = wr_secondary && !reg_wdata[FLAG_BIT];
	assign flag_d       = flag_set || (secondary_q[FLAG_BIT] && !flag_clr);

	always_ff @(posedge clk) begin
		if (rst_int_q) begin
			primary_q   <= PRIMARY_RST;
			secondary_q <= SECONDARY_RST;
			cd_enable_q <= 1'b0;
			cd_src_q    <= SRC_RST;
			square_wave_pin_ctl_q[SQUARE_WAVE_PIN_EN_BIT] <= 1'b1;
			square_wave_pin_ctl_q[1:0] <= FREQ_RST;
		end else begin
			if (wr_primary) begin
				primary_q <= reg_wdata;
			end
			secondary_q <= wr_secondary ? reg_wdata : secondary_q;
			secondary_q[FLAG_BIT] <= flag_d;
			if (wr_cd_ctl) begin
				cd_enable_q <= reg_wdata[ENABLE_BIT];
				cd_src_q    <= reg_wdata[1:0];
			end
			if (wr_square_wave_pin) begin
				square_wave_pin_ctl_q[SQUARE_WAVE_PIN_EN_BIT] <= reg_wdata[SQUARE_WAVE_PIN_EN_BIT];
				square_wave_pin_ctl_q[6:2] <= reg_wdata[6:2];
				square_wave_pin_ctl_q[1:0] <= reg_wdata[1:0];
			end
		end
	end

	// Data bits of alarms survive resets, only bit 7 is set; square_wave_pin also reloads bits 1:0
	for (genvar i = 0; i < 4; i++) begin : g_alarm
		always_ff @(posedge clk) begin
			if (rst_int_q) begin
				alarm_q[i][7] <= 1'b1;
			end else if (wr_alarm && alarm_idx == 2'(i)) begin
				alarm_q[i] <= reg_wdata;
			end
		end
	end

	// Live count, no snapshot: host must read twice to be sure
	always_comb begin
		rdata_d = 8'h00;
		case (reg_addr)
			PRIMARY_CONTROL_OFS:   rdata_d = primary_q;
			SECONDARY_CONTROL_OFS: rdata_d = secondary_q;
			SQUARE_WAVE_PIN_CONTROL_OFS:    rdata_d = square_wave_pin_ctl_q;
			COUNTDOWN_CONTROL_OFS: rdata_d = {cd_enable_q, 5'h00, cd_src_q};
			COUNTDOWN_VALUE_OFS:   rdata_d = cd_count_q;
			default: begin
				if (reg_addr >= ALARM_FIRST_OFS) begin
					rdata_d = alarm_q[alarm_idx];
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reg_ack_q   <= 1'b0;
			reg_rdata_q <= 8'h00;
			iface_rst_q <= 1'b1;
		end else begin
			reg_ack_q   <= (reg_wr || reg_rd) && acc_ok;
			iface_rst_q <= rst_int_q;
			if (reg_rd && acc_ok) begin
				reg_rdata_q <= rdata_d;
			end
		end
	end

	// ************************************************************
	// Prescaler and seconds
	// ************************************************************
	logic [14:0] presc_q;
	logic [5:0]  sec_cnt_q;
	logic [2:0]  ext_tog_q;
	logic        ext_toggle;
	logic        halt;
	logic        ext_mode;
	logic        sec_int;
	logic        sec_any;
	logic        div_rst_q;

	assign halt     = primary_q[HALT_BIT];
	assign ext_mode = primary_q[EXT_TEST_BIT];
	assign sec_int  = osc_tick && !ext_mode && presc_q == SEC_POINT;
	assign sec_any  = sec_int || (ext_mode && ext_tog_q[2] != ext_tog_q[1]);

	always_ff @(posedge clk) begin
		if (rst_int_q) begin
			presc_q <= 15'h0;
		end else if (halt) begin
			presc_q[14:2] <= 13'h0;
			if (osc_tick) begin
				presc_q[1:0] <= presc_q[1:0] + 2'h1;
			end
		end else if (osc_tick) begin
			presc_q <= presc_q + 15'h1;
		end
	end

	// Registered so that no glitch enters the tick domain
	always_ff @(posedge clk) begin
		div_rst_q <= rst_int_q || !ext_mode;
	end

	ext_tick_divider u_ext_div (
		.ext_tick_clk (ext_tick_clk),
		.rst_lvl      (div_rst_q),
		.halt_lvl     (halt),
		.sec_toggle_q (ext_toggle)
	);

	always_ff @(posedge clk) begin
		ext_tog_q <= {ext_tog_q[1:0], ext_toggle};
	end

	always_ff @(posedge clk) begin
		if (rst_int_q) begin
			sec_tick_q <= 1'b0;
			sec_cnt_q  <= 6'h00;
		end else begin
			sec_tick_q <= sec_any;
			if (sec_any) begin
				sec_cnt_q <= sec_cnt_q == SEC_PER_MIN ? 6'h00 : sec_cnt_q + 6'h01;
			end
		end
	end

	// ************************************************************
	// Countdown timer
	// ************************************************************
	logic       src_tick;
	logic       cd_end;
	logic [7:0] pulse_cnt_q;

	// Test mode feeds the 1 Hz and 1/60 Hz sources, stops 64 Hz; 4 kHz still runs off the oscillator
	assign src_tick =
		cd_src_q == SRC_4K   ? osc_tick && presc_q[2:0] == TICK_4K_MASK :
		cd_src_q == SRC_64HZ ? osc_tick && !ext_mode &&
			presc_q[8:0] == TICK_64_MASK :
		cd_src_q == SRC_1HZ  ? sec_any :
		sec_any && sec_cnt_q == SEC_PER_MIN;
	assign cd_end   = cd_enable_q && src_tick && cd_count_q == 8'h01;
	assign flag_set = cd_end;

	always_ff @(posedge clk) begin
		if (wr_cd_val) begin
			cd_count_q <= reg_wdata;
			cd_load_q  <= reg_wdata;
		end else if (cd_end) begin
			cd_count_q <= cd_load_q;
		end else if (cd_enable_q && src_tick && cd_count_q != 8'h00) begin
			cd_count_q <= cd_count_q - 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (rst_int_q) begin
			pulse_cnt_q <= 8'h00;
		end else if (cd_end) begin
			pulse_cnt_q <= 8'(IRQ_PULSE_CYC);
		end else if (pulse_cnt_q != 8'h00) begin
			pulse_cnt_q <= pulse_cnt_q - 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (rst_int_q) begin
			irq_n_q <= 1'b1;
		end else begin
			irq_n_q <= !(secondary_q[IRQ_EN_BIT] &&
				(secondary_q[PULSE_SEL_BIT] ? pulse_cnt_q != 8'h00 :
				secondary_q[FLAG_BIT]));
		end
	end

	// ************************************************************
	// Square wave pin
	// ************************************************************
	logic sq_d;

	always_comb begin
		case (square_wave_pin_ctl_q[1:0])
			2'h0:    sq_d = osc_s_q[2];
			2'h1:    sq_d = presc_q[4];
			2'h2:    sq_d = presc_q[9];
			default: sq_d = presc_q[14];
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst_int_q) begin
			sq_out_q  <= 1'b0;
			sq_oe_n_q <= 1'b0;
		end else begin
			sq_out_q  <= square_wave_pin_ctl_q[SQUARE_WAVE_PIN_EN_BIT] && sq_d;
			sq_oe_n_q <= ext_mode;
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst_int_q);

	sequence s_end_no_wr;
		cd_end && !wr_cd_val;
	endsequence
	sequence s_halted;
		halt [*3];
	endsequence

	property p_reload;
		s_end_no_wr |=> cd_count_q == $past(cd_load_q);
	endproperty
	a_reload: assert property (p_reload) else $error("no reload");
	property p_flag_set;
		s_end_no_wr |=> secondary_q[FLAG_BIT] ##1 secondary_q[FLAG_BIT];
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("flag lost");
	property p_flag_hold;
		secondary_q[FLAG_BIT] && !wr_secondary |=> secondary_q[FLAG_BIT];
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("flag cleared");
	property p_dec;
		cd_enable_q && src_tick && cd_count_q > 8'h01 && !wr_cd_val
			|=> cd_count_q == $past(cd_count_q) - 8'h01;
	endproperty
	a_dec: assert property (p_dec) else $error("bad decrement");
	property p_irq_off;
		!secondary_q[IRQ_EN_BIT] ##1 !secondary_q[IRQ_EN_BIT] |-> irq_n_q;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq driven");
	property p_irq_level;
		secondary_q[IRQ_EN_BIT] && !secondary_q[PULSE_SEL_BIT]
			|=> irq_n_q == !$past(secondary_q[FLAG_BIT]);
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("irq level");
	property p_halt;
		s_halted |-> presc_q[14:2] == 13'h0 && !sec_int;
	endproperty
	a_halt: assert property (p_halt) else $error("prescaler runs");
	property p_halt_out;
		s_halted ##1 (halt && square_wave_pin_ctl_q[1:0] != 2'h0 && !wr_square_wave_pin &&
			$stable(square_wave_pin_ctl_q[1:0]))
			|=> $stable(sq_out_q);
	endproperty
	a_halt_out: assert property (p_halt_out) else $error("output runs");
	property p_ext_pin;
		ext_mode |=> sq_oe_n_q;
	endproperty
	a_ext_pin: assert property (p_ext_pin) else $error("pin driven");
	property p_reset_vals;
		$fell(rst_int_q) |-> primary_q == PRIMARY_RST &&
			secondary_q == SECONDARY_RST && cd_src_q == SRC_RST;
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("reset value");
	property p_refuse;
		@(posedge clk) disable iff (sys_rst)
		rst_int_q ##1 rst_int_q |-> !reg_ack_q;
	endproperty
	a_refuse: assert property (p_refuse) else $error("access in reset");
endmodule : rtc_timebase
`default_nettype wire

//--- rtl/rtc_timebase_pkg.sv
// Purpose: Shared constants for the timebase, countdown and test logic
// Assumes: 100 MHz system clock, 32.768 kHz oscillator level on a pin
// Notes:   Offsets are the register index on the internal access port
package rtc_timebase_pkg;
	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [3:0] PRIMARY_CONTROL_OFS   = 4'h0;
	localparam logic [3:0] SECONDARY_CONTROL_OFS = 4'h1;
	localparam logic [3:0] ALARM_FIRST_OFS       = 4'h9;
	localparam logic [3:0] SQUARE_WAVE_PIN_CONTROL_OFS    = 4'hD;
	localparam logic [3:0] COUNTDOWN_CONTROL_OFS = 4'hE;
	localparam logic [3:0] COUNTDOWN_VALUE_OFS   = 4'hF;

	// ************************************************************
	// Fields and reset values
	// ************************************************************
	localparam int EXT_TEST_BIT   = 7;
	localparam int HALT_BIT       = 5;
	localparam int PERMIT_BIT     = 3;
	localparam int PULSE_SEL_BIT  = 4;
	localparam int FLAG_BIT       = 2;
	localparam int IRQ_EN_BIT     = 0;
	localparam int ENABLE_BIT     = 7;
	localparam int SQUARE_WAVE_PIN_EN_BIT  = 7;
	localparam logic [7:0] PRIMARY_RST   = 8'h08;
	localparam logic [7:0] SECONDARY_RST = 8'h00;
	localparam logic [1:0] SRC_RST       = 2'h3;
	localparam logic [1:0] SRC_4K        = 2'h0;
	localparam logic [1:0] SRC_64HZ      = 2'h1;
	localparam logic [1:0] SRC_1HZ       = 2'h2;
	localparam logic [1:0] FREQ_RST      = 2'h0;

	// ************************************************************
	// Prescaler points and timing
	// ************************************************************
	localparam logic [14:0] SEC_POINT    = 15'h4103;
	localparam logic [2:0]  TICK_4K_MASK = 3'h7;
	localparam logic [8:0]  TICK_64_MASK = 9'h1FF;
	localparam logic [5:0]  SEC_PER_MIN  = 6'h3B;
	localparam int CLK_HZ          = 100_000_000;
	localparam int OSC_STOP_NS     = 100_000;
	localparam int OSC_STOP_CYC    = OSC_STOP_NS / (1_000_000_000 / CLK_HZ);
	localparam int IRQ_PULSE_NS    = 1_000;
	localparam int IRQ_PULSE_CYC   = IRQ_PULSE_NS / (1_000_000_000 / CLK_HZ);
	localparam int OVR_MIN_NS      = 1_000;
	localparam int OVR_MIN_CYC     = (OVR_MIN_NS + 9) / 10;
	localparam int OVR_TOGGLES     = 4;
endpackage : rtc_timebase_pkg

//--- testbench/rtc_host_model.sv
// Purpose: Far side of the block: oscillator and bus-line host
// Assumes: Oscillator runs fast so that counts stay short
// Notes:   Bus lines idle high as with pull-ups
`timescale 1ns/1ns
`default_nettype none
module rtc_host_model
	import rtc_timebase_pkg::*;
(
	input  wire logic clk,
	input  wire logic osc_run,
	input  wire logic ovr_go,
	output logic      osc_pin,
	output logic      scl_pin,
	output logic      sda_pin,
	output logic      ovr_done
);
	initial begin
		osc_pin = 1'b0;
		scl_pin = 1'b1;
		sda_pin = 1'b1;
		ovr_done = 1'b0;
	end

	// Oscillator stops dead when told, to provoke internal reset
	always #100 if (osc_run) osc_pin = ~osc_pin;

	// Override entry pattern, each high phase past the minimum
	always @(posedge ovr_go) begin
		sda_pin = 1'b0;
		repeat (OVR_TOGGLES) begin
			scl_pin = 1'b1;
			repeat (OVR_MIN_CYC + 5) @(posedge clk);
			#1 scl_pin = 1'b0;
			repeat (20) @(posedge clk);
			#1;
		end
		scl_pin = 1'b1;
		sda_pin = 1'b1;
		ovr_done = 1'b1;
	end
endmodule : rtc_host_model
`default_nettype wire

//--- testbench/tb_rtc_timebase.sv
// Purpose: Self-checking bench for the timebase block
// Assumes: 20-cycle oscillator period, so a 4 kHz tick is 160 cycles
// Notes:   Reads are scored by a monitor from a queue of notes
`timescale 1ns/1ns
`default_nettype none
module tb_rtc_timebase;
	import rtc_timebase_pkg::*;
	typedef struct {logic [7:0] e; logic [7:0] m;} note_t;
	logic       clk = 0, sys_rst = 1, ext_tick_clk = 0;
	logic       reg_wr = 0, reg_rd = 0, osc_run = 1, ovr_go = 0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00, q;
	logic       rd_seen = 0, ok;
	wire logic [7:0] reg_rdata_q;
	wire logic  reg_ack_q, iface_rst_q, sec_tick_q, irq_n_q;
	wire logic  sq_out_q, sq_oe_n_q, osc_pin, scl_pin, sda_pin, ovr_done;
	note_t      notes[$], nt;
	int         bad_count = 0, total_checks = 0, ticks = 0, n, v;
	int         seed = 51285;
	int         b[4] = '{31, 1, 63, 1};

	rtc_timebase #(.OSC_STOP_CYCLES(200)) i_rtc_timebase (.clk(clk),
		.sys_rst(sys_rst), .osc_pin(osc_pin), .scl_pin(scl_pin),
		.sda_pin(sda_pin), .ext_tick_clk(ext_tick_clk), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata_q(reg_rdata_q), .reg_ack_q(reg_ack_q),
		.iface_rst_q(iface_rst_q), .sec_tick_q(sec_tick_q),
		.irq_n_q(irq_n_q), .sq_out_q(sq_out_q), .sq_oe_n_q(sq_oe_n_q));
	rtc_host_model i_rtc_host_model (.clk(clk), .osc_run(osc_run),
		.ovr_go(ovr_go), .osc_pin(osc_pin), .scl_pin(scl_pin),
		.sda_pin(sda_pin), .ovr_done(ovr_done));

	always #5 clk = ~clk;

	// ****************************************************
	// Shared tasks
	// ****************************************************
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : cyc
	// One-cycle strobe; ack looked for on the next edges, bounded
	task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
		reg_wr = w;
		reg_rd = !w;
		reg_addr = a;
		reg_wdata = d;
		cyc(1);
		reg_wr = 0;
		reg_rd = 0;
		ok = 0;
		for (int i = 0; i < 3 && !ok; i++) begin
			@(posedge clk);
			if (reg_ack_q === 1'b1) begin
				ok = 1;
				q = reg_rdata_q;
			end
		end
		#1;
	endtask : acc
	// Mask zero marks a poll whose value is judged elsewhere
	task automatic rdx(input logic [3:0] a, input logic [7:0] e, m);
		notes.push_back('{e, m});
		acc(0, a, 8'h00);
	endtask : rdx
	task automatic wait_irq(input logic lvl, input int lim);
		n = 0;
		while (irq_n_q !== lvl && n < lim) begin
			cyc(1);
			n++;
		end
	endtask : wait_irq
	task automatic burst(input int k);
		repeat (k) begin
			#3 ext_tick_clk = 1;
			#3 ext_tick_clk = 0;
		end
		cyc(10);
	endtask : burst
	task automatic wrap_up;
		if (bad_count == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : wrap_up

	always @(posedge clk) begin
		if (reg_ack_q === 1'b1 && rd_seen) begin
			nt = '{8'hEE, 8'hFF};
			if (notes.size() > 0) nt = notes.pop_front();
			if (nt.m != 8'h00) chk(reg_rdata_q & nt.m, nt.e);
		end
		rd_seen = (reg_rd === 1'b1);
		if (sec_tick_q === 1'b1) ticks++;
	end

	initial begin
		#800_000;
		bad_count++;
		wrap_up;
	end

	// ****************************************************
	// Scenarios
	// ****************************************************
	initial begin
		cyc(3);
		sys_rst = 0;
		cyc(2);
		burst(4);
		rdx(PRIMARY_CONTROL_OFS, PRIMARY_RST, 8'hFF);
		rdx(SECONDARY_CONTROL_OFS, SECONDARY_RST, 8'hFF);
		rdx(COUNTDOWN_CONTROL_OFS, 8'h03, 8'h83);
		rdx(SQUARE_WAVE_PIN_CONTROL_OFS, 8'h80, 8'h83);
		for (int a = 9; a < 13; a++) rdx(4'(a), 8'h80, 8'h80);
		rdx(4'h3, 8'h00, 8'hFF);
		v = 2 + ($random(seed) & 3);
		acc(1, COUNTDOWN_VALUE_OFS, 8'(v));
		rdx(COUNTDOWN_VALUE_OFS, 8'(v), 8'hFF);
		acc(1, SECONDARY_CONTROL_OFS, 8'h01);
		acc(1, COUNTDOWN_CONTROL_OFS, 8'h80);
		rdx(COUNTDOWN_VALUE_OFS, 8'h00, 8'h00);
		chk(8'(q >= 1 && q <= v), 8'h01);
		wait_irq(0, 2000);
		chk(8'(n > (v - 1) * 160 - 10 && n < v * 160 + 20), 8'h01);
		cyc(v * 320);
		chk(8'(irq_n_q), 8'h00);
		rdx(SECONDARY_CONTROL_OFS, 8'h04, 8'h04);
		acc(1, SECONDARY_CONTROL_OFS, 8'h01);
		cyc(3);
		chk(8'(irq_n_q), 8'h01);
		wait_irq(0, v * 160 + 40);
		chk(8'(n < v * 160 + 40), 8'h01);
		acc(1, SECONDARY_CONTROL_OFS, 8'h11);
		cyc(120);
		wait_irq(0, v * 160 + 40);
		wait_irq(1, 200);
		chk(8'(n >= IRQ_PULSE_CYC - 2 && n <= IRQ_PULSE_CYC + 2), 8'h01);
		rdx(SECONDARY_CONTROL_OFS, 8'h04, 8'h04);
		acc(1, SECONDARY_CONTROL_OFS, 8'h14);
		cyc(v * 160 + 40);
		chk(8'(irq_n_q), 8'h01);
		acc(1, COUNTDOWN_CONTROL_OFS, 8'h00);
		acc(1, SECONDARY_CONTROL_OFS, 8'h00);
		cyc(v * 160 + 40);
		rdx(SECONDARY_CONTROL_OFS, 8'h00, 8'h04);
		acc(1, PRIMARY_CONTROL_OFS, 8'h28);
		for (int s = 0; s < 2; s++) begin
			acc(1, SQUARE_WAVE_PIN_CONTROL_OFS, s ? 8'h81 : 8'h80);
			cyc(20);
			n = 0;
			q[0] = sq_out_q;
			repeat (200) begin
				cyc(1);
				n += (sq_out_q !== q[0]);
				q[0] = sq_out_q;
			end
			chk(8'(s ? n == 0 : n >= 10), 8'h01);
		end
		acc(1, PRIMARY_CONTROL_OFS, 8'hA8);
		cyc(2);
		chk(8'(sq_oe_n_q), 8'h01);
		burst(64);
		chk(8'(ticks), 8'h00);
		acc(1, PRIMARY_CONTROL_OFS, 8'h88);
		cyc(5);
		for (int i = 0; i < 4; i++) begin
			burst(b[i]);
			chk(8'(ticks), 8'(i - i / 2 - (i == 0 ? 0 : 0)));
		end
		acc(1, PRIMARY_CONTROL_OFS, 8'h08);
		osc_run = 0;
		cyc(300);
		chk(8'(iface_rst_q), 8'h01);
		acc(1, SQUARE_WAVE_PIN_CONTROL_OFS, 8'h00);
		chk(8'(ok), 8'h00);
		ovr_go = 1;
		n = 0;
		while (ovr_done !== 1'b1 && n < 2000) begin
			cyc(1);
			n++;
		end
		cyc(4);
		chk(8'(iface_rst_q), 8'h00);
		rdx(PRIMARY_CONTROL_OFS, 8'h08, 8'hFF);
		rdx(SQUARE_WAVE_PIN_CONTROL_OFS, 8'h80, 8'h83);
		acc(1, PRIMARY_CONTROL_OFS, 8'h88);
		cyc(2);
		chk(8'(sq_oe_n_q), 8'h01);
		acc(1, PRIMARY_CONTROL_OFS, 8'h00);
		cyc(4);
		chk(8'(iface_rst_q), 8'h01);
		osc_run = 1;
		n = 0;
		while (iface_rst_q !== 1'b0 && n < 200) begin
			cyc(1);
			n++;
		end
		chk(8'(iface_rst_q), 8'h00);
		acc(1, COUNTDOWN_CONTROL_OFS, 8'h03);
		wrap_up;
	end
endmodule : tb_rtc_timebase
`default_nettype wire
